// *** hw/timer_pkg.sv ***
// Constants for the dual counter/timer control and mode logic.
package timer_pkg;

  localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
  localparam logic [7:0] ADDR_LOW_BYTE_TMR_ZERO = 8'h8a;
  localparam logic [7:0] ADDR_LOW_BYTE_TMR_ONE = 8'h8b;
  localparam logic [7:0] ADDR_HIGH_BYTE_TMR_ZERO = 8'h8c;
  localparam logic [7:0] ADDR_HIGH_BYTE_TMR_ONE = 8'h8d;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  localparam int BIT_OVF_FLAG_TMR_ONE = 7;
  localparam int BIT_RUN_BIT_TMR_ONE = 6;
  localparam int BIT_OVF_FLAG_TMR_ZERO = 5;
  localparam int BIT_RUN_BIT_TMR_ZERO = 4;
  localparam int BIT_EXT_IRQ_FLAG_ONE = 3;
  localparam int BIT_EXT_IRQ_TYPE_ONE = 2;
  localparam int BIT_EXT_IRQ_FLAG_ZERO = 1;
  localparam int BIT_EXT_IRQ_TYPE_ZERO = 0;

  localparam int BIT_GATE_SEL_TMR_ONE = 7;
  localparam int BIT_COUNT_SEL_TMR_ONE = 6;
  localparam int BIT_MODE_FIELD_TMR_ONE = 4;
  localparam int BIT_GATE_SEL_TMR_ZERO = 3;
  localparam int BIT_COUNT_SEL_TMR_ZERO = 2;
  localparam int BIT_MODE_FIELD_TMR_ZERO = 0;

  typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} tmr_mode_type;

  localparam logic [1:0] PRESCALE_SYS_DIV12 = 2'h0;
  localparam logic [1:0] PRESCALE_SYS_DIV4 = 2'h1;
  localparam logic [1:0] PRESCALE_SYS_DIV48 = 2'h2;
  localparam logic [1:0] PRESCALE_EXT_DIV8 = 2'h3;
  localparam logic [5:0] DIVIDE_12 = 6'h0c;
  localparam logic [5:0] DIVIDE_4 = 6'h04;
  localparam logic [5:0] DIVIDE_48 = 6'h30;
  localparam logic [5:0] DIVIDE_8 = 6'h08;

endpackage

// *** hw/edge_sync.sv ***
// Two-stage synchroniser with a third stage kept for edge detection.
`timescale 1ns/1ps
module edge_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic din,
  output logic lvl,
  output logic prev
);

  typedef struct packed {
    logic meta;
    logic lvl;
    logic prev;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  // The first stage feeds only the second; edges compare the two later stages.
  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.meta = din;
      s_d.lvl = s_q.meta;
      s_d.prev = s_q.lvl;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign lvl = s_q.lvl;
  assign prev = s_q.prev;

endmodule // edge_sync

// *** hw/dual_timer_control_and_mode.sv ***
// Control, mode and counting logic for two counter/timers and two external interrupt flags.
`timescale 1ns/1ps
module dual_timer_control_and_mode (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic vec_tmr_zero,
  input wire logic vec_tmr_one,
  input wire logic vec_irq_zero,
  input wire logic vec_irq_one,
  input wire logic count_pin_zero,
  input wire logic count_pin_one,
  input wire logic ext_irq_input_zero,
  input wire logic ext_irq_input_one,
  input wire logic polarity_irq_zero,
  input wire logic polarity_irq_one,
  input wire logic [1:0] prescale_select,
  input wire logic clk_sel_tmr_zero,
  input wire logic clk_sel_tmr_one,
  input wire logic ext_clk,
  output logic [7:0] sfr_rdata,
  output logic [7:0] timer_control_out,
  output logic ovf_pulse_tmr_one
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] lo0;
    logic [7:0] hi0;
    logic [7:0] lo1;
    logic [7:0] hi1;
    logic [5:0] pre;
    logic [7:0] rd;
    logic pulse1;
    logic [1:0] warm;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic pin0_lvl, pin0_prev, pin1_lvl, pin1_prev;
  logic irq0_lvl, irq0_prev, irq1_lvl, irq1_prev;
  logic ext_lvl, ext_prev;

  edge_sync u_sync_pin0 (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .din(count_pin_zero), .lvl(pin0_lvl), .prev(pin0_prev));
  edge_sync u_sync_pin1 (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .din(count_pin_one), .lvl(pin1_lvl), .prev(pin1_prev));
  edge_sync u_sync_irq0 (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .din(ext_irq_input_zero), .lvl(irq0_lvl), .prev(irq0_prev));
  edge_sync u_sync_irq1 (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .din(ext_irq_input_one), .lvl(irq1_lvl), .prev(irq1_prev));
  edge_sync u_sync_ext (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .din(ext_clk), .lvl(ext_lvl), .prev(ext_prev));

  // Returns {overflow, high byte, low byte} after one increment in the given mode, or unchanged in split mode.
  function automatic logic [16:0] step(input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] md);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [16:0] r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h0_0001;
    r = {1'b0, hi, lo};
    case (md)
      timer_pkg::MODE_13BIT: r = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      timer_pkg::MODE_16BIT: r = s16;
      timer_pkg::MODE_RELOAD8: r = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, 8'(lo + 8'h01)};
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  logic [1:0] md0, md1;
  logic split0, act0, act1, edge0, edge1, pre_inc, pre_tick, sync_ok;
  logic en0, en1, tick0, tick1, inc0, inc1, inc_hi0, set_tf0, set_tf1, ovf1;
  logic [5:0] divide;
  logic [16:0] nxt0, nxt1;

  always_comb begin
    md0 = s_q.mode[timer_pkg::BIT_MODE_FIELD_TMR_ZERO +: 2];
    md1 = s_q.mode[timer_pkg::BIT_MODE_FIELD_TMR_ONE +: 2];
    split0 = (md0 == timer_pkg::MODE_SPLIT);
    // Synchronisers reset low, which an active-low input would read as active until the pin reaches them.
    sync_ok = (s_q.warm == 2'h3);
    act0 = sync_ok && (irq0_lvl == polarity_irq_zero);
    act1 = sync_ok && (irq1_lvl == polarity_irq_one);
    edge0 = act0 && (irq0_prev != polarity_irq_zero);
    edge1 = act1 && (irq1_prev != polarity_irq_one);
    case (prescale_select)
      timer_pkg::PRESCALE_SYS_DIV12: divide = timer_pkg::DIVIDE_12;
      timer_pkg::PRESCALE_SYS_DIV4: divide = timer_pkg::DIVIDE_4;
      timer_pkg::PRESCALE_SYS_DIV48: divide = timer_pkg::DIVIDE_48;
      default: divide = timer_pkg::DIVIDE_8;
    endcase
    // The external clock is counted on its synchronised falling edges only.
    pre_inc = (prescale_select == timer_pkg::PRESCALE_EXT_DIV8) ? (ext_prev && !ext_lvl) : 1'b1;
    pre_tick = pre_inc && (s_q.pre >= 6'(divide - 6'h01));
    en0 = s_q.ctrl[timer_pkg::BIT_RUN_BIT_TMR_ZERO] && (!s_q.mode[timer_pkg::BIT_GATE_SEL_TMR_ZERO] || act0);
    en1 = s_q.ctrl[timer_pkg::BIT_RUN_BIT_TMR_ONE] && (!s_q.mode[timer_pkg::BIT_GATE_SEL_TMR_ONE] || act1);
    tick0 = s_q.mode[timer_pkg::BIT_COUNT_SEL_TMR_ZERO] ? (pin0_prev && !pin0_lvl) : (clk_sel_tmr_zero || pre_tick);
    tick1 = (clk_sel_tmr_one || pre_tick);
    // With timer zero split, timer one loses its pin input and its run bit.
    if (!split0 && s_q.mode[timer_pkg::BIT_COUNT_SEL_TMR_ONE]) begin
      tick1 = pin1_prev && !pin1_lvl;
    end
    inc0 = en0 && tick0;
    inc1 = (split0 || en1) && (md1 != timer_pkg::MODE_SPLIT) && tick1;
    inc_hi0 = split0 && s_q.ctrl[timer_pkg::BIT_RUN_BIT_TMR_ONE] && (clk_sel_tmr_one || pre_tick);
    nxt0 = step(s_q.lo0, s_q.hi0, md0);
    nxt1 = step(s_q.lo1, s_q.hi1, md1);
    if (split0) begin
      nxt0 = {(s_q.lo0 == 8'hff), 8'(s_q.hi0 + 8'h01), 8'(s_q.lo0 + 8'h01)};
    end
    set_tf0 = inc0 && nxt0[16];
    ovf1 = inc1 && nxt1[16];
    set_tf1 = (!split0 && ovf1) || (inc_hi0 && s_q.hi0 == 8'hff);
  end

  always_comb begin
    s_d = s_q;
    if (ce) begin
      if (split0) begin
        if (inc0) s_d.lo0 = nxt0[7:0];
        if (inc_hi0) s_d.hi0 = nxt0[15:8];
      end else if (inc0) begin
        s_d.lo0 = nxt0[7:0];
        s_d.hi0 = nxt0[15:8];
      end
      if (inc1) begin
        s_d.lo1 = nxt1[7:0];
        s_d.hi1 = nxt1[15:8];
      end
      s_d.pulse1 = ovf1;
      s_d.warm = sync_ok ? s_q.warm : s_q.warm + 2'h1;
      s_d.pre = pre_tick ? 6'h00 : 6'(s_q.pre + {5'h00, pre_inc});
      // Vectoring clears overflow flags always, interrupt flags only when edge triggered.
      if (vec_tmr_one) s_d.ctrl[timer_pkg::BIT_OVF_FLAG_TMR_ONE] = 1'b0;
      if (vec_tmr_zero) s_d.ctrl[timer_pkg::BIT_OVF_FLAG_TMR_ZERO] = 1'b0;
      if (vec_irq_one && s_q.ctrl[timer_pkg::BIT_EXT_IRQ_TYPE_ONE]) s_d.ctrl[timer_pkg::BIT_EXT_IRQ_FLAG_ONE] = 1'b0;
      if (vec_irq_zero && s_q.ctrl[timer_pkg::BIT_EXT_IRQ_TYPE_ZERO]) s_d.ctrl[timer_pkg::BIT_EXT_IRQ_FLAG_ZERO] = 1'b0;
      if (bit_wr) s_d.ctrl[bit_sel] = bit_val;
      if (sfr_wr) begin
        case (sfr_addr)
          timer_pkg::ADDR_TIMER_CONTROL: s_d.ctrl = sfr_wdata;
          timer_pkg::ADDR_TIMER_MODE: s_d.mode = sfr_wdata;
          timer_pkg::ADDR_LOW_BYTE_TMR_ZERO: s_d.lo0 = sfr_wdata;
          timer_pkg::ADDR_LOW_BYTE_TMR_ONE: s_d.lo1 = sfr_wdata;
          timer_pkg::ADDR_HIGH_BYTE_TMR_ZERO: s_d.hi0 = sfr_wdata;
          timer_pkg::ADDR_HIGH_BYTE_TMR_ONE: s_d.hi1 = sfr_wdata;
          default: s_d.ctrl = s_d.ctrl;
        endcase
      end
      // Hardware sets come last so an event in a clearing cycle is never lost.
      if (set_tf1) s_d.ctrl[timer_pkg::BIT_OVF_FLAG_TMR_ONE] = 1'b1;
      if (set_tf0) s_d.ctrl[timer_pkg::BIT_OVF_FLAG_TMR_ZERO] = 1'b1;
      if (s_q.ctrl[timer_pkg::BIT_EXT_IRQ_TYPE_ONE] ? edge1 : act1) begin
        s_d.ctrl[timer_pkg::BIT_EXT_IRQ_FLAG_ONE] = 1'b1;
      end
      if (s_q.ctrl[timer_pkg::BIT_EXT_IRQ_TYPE_ZERO] ? edge0 : act0) begin
        s_d.ctrl[timer_pkg::BIT_EXT_IRQ_FLAG_ZERO] = 1'b1;
      end
      if (sfr_rd) begin
        case (sfr_addr)
          timer_pkg::ADDR_TIMER_CONTROL: s_d.rd = s_q.ctrl;
          timer_pkg::ADDR_TIMER_MODE: s_d.rd = s_q.mode;
          timer_pkg::ADDR_LOW_BYTE_TMR_ZERO: s_d.rd = s_q.lo0;
          timer_pkg::ADDR_LOW_BYTE_TMR_ONE: s_d.rd = s_q.lo1;
          timer_pkg::ADDR_HIGH_BYTE_TMR_ZERO: s_d.rd = s_q.hi0;
          timer_pkg::ADDR_HIGH_BYTE_TMR_ONE: s_d.rd = s_q.hi1;
          default: s_d.rd = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q.ctrl <= timer_pkg::CONTROL_RESET;
      s_q.mode <= timer_pkg::MODE_RESET;
      s_q.lo0 <= timer_pkg::BYTE_RESET;
      s_q.hi0 <= timer_pkg::BYTE_RESET;
      s_q.lo1 <= timer_pkg::BYTE_RESET;
      s_q.hi1 <= timer_pkg::BYTE_RESET;
      s_q.pre <= 6'h00;
      s_q.rd <= 8'h00;
      s_q.pulse1 <= 1'b0;
      s_q.warm <= 2'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rd;
  assign timer_control_out = s_q.ctrl;
  assign ovf_pulse_tmr_one = s_q.pulse1;

  logic wr_t0;
  assign wr_t0 = sfr_wr && (sfr_addr == timer_pkg::ADDR_LOW_BYTE_TMR_ZERO || sfr_addr == timer_pkg::ADDR_HIGH_BYTE_TMR_ZERO);

  sequence s_irq1_rise;
    (ce && s_q.ctrl[2] && !act1) ##1 (ce && s_q.ctrl[2] && act1);
  endsequence

  sequence s_pin0_fall_counted;
    (ce && pin0_lvl) ##1 (ce && !pin0_lvl && en0 && s_q.mode[2] && md0 == 2'h1 && !wr_t0);
  endsequence

  a_ovf_zero_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && set_tf0 |=> s_q.ctrl[5]) else $error("Timer zero overflow flag not set.");
  a_ovf_one_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && set_tf1 |=> s_q.ctrl[7]) else $error("Timer one overflow flag not set.");
  a_stop_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && !s_q.ctrl[4] && !split0 && !wr_t0 |=> $stable(s_q.lo0)) else $error("Timer zero counted while stopped.");
  a_gate_blocks: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && s_q.mode[3] && !act0 |-> !inc0) else $error("Gated timer zero counted while input inactive.");
  a_edge_irq_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_irq1_rise |=> s_q.ctrl[3]) else $error("Edge on interrupt one input missed.");
  a_level_irq_set: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && !s_q.ctrl[0] && act0 |=> s_q.ctrl[1]) else $error("Level on interrupt zero input missed.");
  a_vector_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && vec_irq_one && s_q.ctrl[2] && !edge1 && !bit_wr && !sfr_wr |=> !s_q.ctrl[3]) else $error("Vector clear failed.");
  a_reload_low: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && md0 == 2'h2 && inc0 && s_q.lo0 == 8'hff && !wr_t0 |=> s_q.lo0 == $past(s_q.hi0) && s_q.ctrl[5])
    else $error("Reload from high byte failed.");
  a_pin_count: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_pin0_fall_counted |=> s_q.lo0 == 8'($past(s_q.lo0) + 8'h01)) else $error("Pin fall not counted once.");
  a_bit_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && bit_wr && bit_sel == 3'h4 && !sfr_wr |=> s_q.ctrl[4] == $past(bit_val)) else $error("Bit write lost.");

endmodule // dual_timer_control_and_mode

// *** tb/pin_model.sv ***
// Behavioural model of the external count, interrupt and clock pins.
`timescale 1ns/1ps
module pin_model (
  input wire logic core_clk,
  output logic count_pin_zero,
  output logic count_pin_one,
  output logic ext_irq_input_zero,
  output logic ext_irq_input_one,
  output logic ext_clk
);
  initial begin
    count_pin_zero = 1'b1;
    count_pin_one = 1'b1;
    ext_irq_input_zero = 1'b0;
    ext_irq_input_one = 1'b1;
    ext_clk = 1'b0;
  end
  // The external oscillator runs free and has no phase relation to the core clock.
  always #37 ext_clk = ~ext_clk;
  // Each pulse holds the pin low for two cycles and high for two, so the synchroniser sees every fall.
  task automatic fall(input logic which, input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (which) count_pin_one = 1'b0; else count_pin_zero = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      if (which) count_pin_one = 1'b1; else count_pin_zero = 1'b1;
      @(posedge core_clk);
    end
  endtask
  task automatic irq(input logic which, input logic val);
    @(posedge core_clk);
    #1;
    if (which) ext_irq_input_one = val; else ext_irq_input_zero = val;
  endtask
endmodule // pin_model

// *** tb/dual_timer_control_and_mode_test.sv ***
// Self-checking testbench for the dual counter/timer control and mode logic.
`timescale 1ns/1ps
module dual_timer_control_and_mode_test;
  logic core_clk, rst_b, sfr_wr, sfr_rd, bit_wr, bit_val, rd_seen;
  logic vec_tmr_zero, vec_tmr_one, vec_irq_zero, vec_irq_one;
  logic cp0, cp1, irq0, irq1, pol0, pol1, cs0, cs1, eclk, ovf1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, tc_out, rel;
  logic [2:0] bit_sel;
  logic [1:0] psel;
  logic [7:0] exp_q[$];
  int bad_count, checked;
  dual_timer_control_and_mode dual_timer_control_and_mode_inst (
    .core_clk(core_clk), .rst_b(rst_b), .ce(1'b1), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val),
    .vec_tmr_zero(vec_tmr_zero), .vec_tmr_one(vec_tmr_one), .vec_irq_zero(vec_irq_zero),
    .vec_irq_one(vec_irq_one), .count_pin_zero(cp0), .count_pin_one(cp1), .ext_irq_input_zero(irq0),
    .ext_irq_input_one(irq1), .polarity_irq_zero(pol0), .polarity_irq_one(pol1), .prescale_select(psel),
    .clk_sel_tmr_zero(cs0), .clk_sel_tmr_one(cs1), .ext_clk(eclk), .sfr_rdata(sfr_rdata),
    .timer_control_out(tc_out), .ovf_pulse_tmr_one(ovf1));
  pin_model pin_model_inst (.core_clk(core_clk), .count_pin_zero(cp0), .count_pin_one(cp1),
    .ext_irq_input_zero(irq0), .ext_irq_input_one(irq1), .ext_clk(eclk));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_wr = 1'b0;
  endtask
  // The expected value is noted first; the monitor below takes it off when the read data appears.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    #1;
    exp_q.push_back(e);
    sfr_addr = a; sfr_rd = 1'b1;
    @(posedge core_clk);
    #1;
    sfr_rd = 1'b0;
  endtask
  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge core_clk);
    #1;
    bit_sel = s; bit_val = v; bit_wr = 1'b1;
    @(posedge core_clk);
    #1;
    bit_wr = 1'b0;
  endtask
  task automatic vec(input int k);
    @(posedge core_clk);
    #1;
    {vec_irq_one, vec_irq_zero, vec_tmr_one, vec_tmr_zero} = 4'b0001 << k;
    @(posedge core_clk);
    #1;
    {vec_irq_one, vec_irq_zero, vec_tmr_one, vec_tmr_zero} = 4'b0000;
  endtask
  always @(posedge core_clk) begin
    rd_seen <= sfr_rd;
    if (rd_seen && exp_q.size() > 0) check("sfr_rdata", sfr_rdata, exp_q.pop_front());
  end
  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end
  initial begin
    int i;
    {sfr_wr, sfr_rd, bit_wr, bit_val, rd_seen, sfr_addr, sfr_wdata, bit_sel} = '0;
    {vec_irq_one, vec_irq_zero, vec_tmr_one, vec_tmr_zero} = 4'b0000;
    pol0 = 1'b1; pol1 = 1'b0; cs0 = 1'b0; cs1 = 1'b0; psel = 2'h0;
    bad_count = 0; checked = 0; rst_b = 1'b0;
    void'($urandom(32'h4a3ede3d));
    rel = 8'($urandom());
    repeat (20) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    rd(8'h8e, 8'h00);
    // Sixteen-bit counter on pin falls, wrapping from all ones.
    wr(8'h89, 8'h05);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hfd);
    bw(3'h4, 1'b1);
    rd(8'h88, 8'h10);
    pin_model_inst.fall(1'b0, 3);
    repeat (6) @(posedge core_clk);
    rd(8'h8a, 8'h00);
    rd(8'h8c, 8'h00);
    rd(8'h88, 8'h30);
    vec(0);
    rd(8'h88, 8'h10);
    // Thirteen-bit counter carries out of the low five bits.
    wr(8'h89, 8'h04);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'h1e);
    pin_model_inst.fall(1'b0, 2);
    repeat (6) @(posedge core_clk);
    rd(8'h8a, 8'h00);
    rd(8'h8c, 8'h00);
    rd(8'h88, 8'h30);
    wr(8'h88, 8'h10);
    // Eight-bit reload with a random reload value.
    wr(8'h89, 8'h06);
    wr(8'h8c, rel);
    wr(8'h8a, 8'hff);
    pin_model_inst.fall(1'b0, 1);
    repeat (6) @(posedge core_clk);
    rd(8'h8a, rel);
    rd(8'h8c, rel);
    rd(8'h88, 8'h30);
    // Gated counting follows the interrupt zero input.
    wr(8'h89, 8'h0d);
    wr(8'h8c, 8'h00);
    wr(8'h8a, 8'h00);
    pin_model_inst.fall(1'b0, 2);
    repeat (6) @(posedge core_clk);
    rd(8'h8a, 8'h00);
    pin_model_inst.irq(1'b0, 1'b1);
    repeat (5) @(posedge core_clk);
    pin_model_inst.fall(1'b0, 2);
    repeat (6) @(posedge core_clk);
    rd(8'h8a, 8'h02);
    pin_model_inst.irq(1'b0, 1'b0);
    repeat (5) @(posedge core_clk);
    wr(8'h88, 8'h00);
    // Timer one on the system clock in reload mode, then stopped by the inactive mode.
    cs1 = 1'b1;
    wr(8'h89, 8'h20);
    wr(8'h8d, 8'hfe);
    wr(8'h8b, 8'hfe);
    bw(3'h6, 1'b1);
    i = 0;
    while (ovf1 !== 1'b1 && i < 50) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    check("ovf_pulse_tmr_one", {7'h00, ovf1}, 8'h01);
    rd(8'h88, 8'hc0);
    // Stop the timer first, otherwise a new wrap sets the flag again right after the vector clears it.
    bw(3'h6, 1'b0);
    rd(8'h88, 8'h80);
    vec(1);
    rd(8'h88, 8'h00);
    wr(8'h89, 8'h30);
    bw(3'h6, 1'b1);
    wr(8'h8b, 8'h55);
    repeat (4) @(posedge core_clk);
    rd(8'h8b, 8'h55);
    wr(8'h88, 8'h01);
    // Edge and level sensitive external interrupt flags.
    pin_model_inst.irq(1'b0, 1'b1);
    repeat (6) @(posedge core_clk);
    rd(8'h88, 8'h03);
    vec(2);
    rd(8'h88, 8'h01);
    pin_model_inst.irq(1'b1, 1'b0);
    repeat (6) @(posedge core_clk);
    rd(8'h88, 8'h09);
    repeat (3) @(posedge core_clk);
    end_of_test();
  end
endmodule // dual_timer_control_and_mode_test
